// ### verilog/pmcp_top.sv
// Program memory protection unit: lock bytes, ID bytes, table and serial access checks
//Contract
//(RL1) Memory splits into boot, block0 1000h-1FFFh and block1 2000h-3FFFh.
//(RL2) Boot region starts at zero, ends 07FFh or 0FFFh by size bit.
//(RL3) Each region has external lock, table-write lock and cross-read lock.
//(RL4) Core table reads and writes reach all memory, only region locks apply; the code also refuses core writes from 3E00h while the debugger is on.
//(RL5) External lock never affects core accesses.
//(RL6) External lock refuses serial reads and writes of its region.
//(RL7) Write lock at zero blocks core table writes to the region.
//(RL8) Read lock at zero still lets code inside the region read it.
//(RL9) Read lock at zero gives zero data to code outside the region.
//(RL10) Protection bits only go from one to zero on writes.
//(RL11) Only serial chip or region erase sets protection bits to one.
//(RL12) Config write lock is read-only to core, serial port changes it.
//(RL13) Config bytes readable and writable by core, subject to config lock.
//(RL14) Device identification word is readable by core table reads.
//(RL15) Eight ID bytes at 200000h-200007h, read and write by table and serial.
//(RL16) ID bytes stay readable whatever the code protection.
//(RL17) Serial programming uses one clock line and one data line.
//(RL18) Debug bit zero enables debugger, reserving pins, stack and memory; the code reserves the pins and refuses core writes from 3E00h, but no stack.
//(RL19) Read permission compares region of executing and target addresses.
`timescale 1ns/10ps
`default_nettype none
module pmcp_top
   import pmcp_pkg::*;
#(
   parameter logic [15:0] DEV_ID = 16'h5A5A   // Arbitrary neutral value
)(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   // Core table access
   input  wire logic        tbl_req_in,
   input  wire logic        tbl_wr_in,
   input  wire logic [21:0] tbl_addr_in,
   input  wire logic [21:0] tbl_exec_addr_in,
   input  wire logic [7:0]  tbl_wdata_in,
   output logic             tbl_ready_out,
   output logic             tbl_ack_out,
   output logic             tbl_blocked_out,
   output logic [7:0]       tbl_rdata_out,
   // Program flash
   input  wire logic [7:0]  mem_rdata_in,
   output logic [21:0]      mem_addr_out,
   output logic [7:0]       mem_wdata_out,
   output logic             mem_we_out,
   output logic             mem_erase_out,
   output logic             mem_erase_all_out,
   output logic [1:0]       mem_erase_rgn_out,
   // Serial programming pins
   input  wire logic        prog_mode_in,
   input  wire logic        pgc_in,
   input  wire logic        pgd_in,
   output logic             pgd_out,
   output logic             pgd_oe_out,
   // Debugger
   output logic             dbg_en_out,
   output logic [1:0]       dbg_pins_out
);
   typedef struct packed {
      pmcp_state_t     st;
      logic            wr;
      logic [21:0]     addr;
      logic [7:0]      wdata;
      logic [1:0]      xrgn;
      logic [2:0]      cp;   // RL3
      logic [2:0]      wrt;
      logic [2:0]      ebtr;
      logic            config_write_lock;
      logic            dbg_en;
      logic            boot2k;
      logic [7:0][7:0] id;
      logic            ready;
      logic            ack;
      logic            blocked;
      logic [7:0]      rdata;
      logic            we;
      logic            erase;
      logic            erase_all;
      logic [1:0]      erase_rgn;
      logic            pgc_s1;
      logic            pgc_s2;
      logic            pgc_d;
      logic            pgd_s1;
      logic            pgd_s2;
      logic            pm_s1;
      logic            pm_s2;
      logic [35:0]     sh;
      logic [5:0]      cnt;
      logic            ext_pend;
      logic [3:0]      txcnt;
      logic [7:0]      tx;
      logic            oe;
   } pmcp_st_t;

   // Locks come up erased: this model holds no nonvolatile image
   localparam pmcp_st_t S_RST = '{st: ST_IDLE, cp: LOCK_RST, wrt: LOCK_RST, ebtr: LOCK_RST,
                                  config_write_lock: 1'b1, id: {8{ID_RST}}, ready: 1'b1, default: '0};

   pmcp_st_t s;
   pmcp_st_t n;
   logic [1:0] rgn;
   logic [1:0] er_rgn;
   logic       prog;
   logic       lk;
   logic       is_id;
   logic       is_cfg;
   logic       dbgr;
   logic       ext;
   logic       deny;
   logic       rise;
   logic [7:0] rd;

   // Region of an address; boot end follows the size bit
   function automatic logic [1:0] pmcp_rgn(input logic [21:0] a, input logic b2k);
      if (a <= (b2k ? BOOT_END_2K : BOOT_END_1K))
         pmcp_rgn = RGN_BOOT; // RL2
      else if (a >= BLK0_LO && a <= BLK0_HI)
         pmcp_rgn = RGN_B0; // RL1
      else if (a >= BLK1_LO && a <= BLK1_HI)
         pmcp_rgn = RGN_B1; // RL1
      else
         pmcp_rgn = RGN_NONE;
   endfunction : pmcp_rgn

   // Next state
   always_comb begin
      n = s;
      n.ack = 1'b0;
      n.blocked = 1'b0;
      n.we = 1'b0;
      n.erase = 1'b0;
      n.erase_all = 1'b0;
      er_rgn = RGN_NONE;
      // Pins cross in through two flops; only the second is read
      n.pgc_s1 = pgc_in;
      n.pgc_s2 = s.pgc_s1;
      n.pgc_d = s.pgc_s2;
      n.pgd_s1 = pgd_in;
      n.pgd_s2 = s.pgd_s1;
      n.pm_s1 = prog_mode_in;
      n.pm_s2 = s.pm_s1;
      rise = s.pgc_s2 & ~s.pgc_d;
      // Target decode of the access in flight
      rgn = pmcp_rgn(s.addr, s.boot2k);
      prog = s.addr <= BLK1_HI;
      lk = prog && rgn != RGN_NONE;
      is_id = s.addr >= ID_LO && s.addr <= ID_HI;
      is_cfg = s.addr >= CFG_LO && s.addr <= CFG_HI;
      dbgr = s.dbg_en && s.addr >= DBG_RSV_LO && prog; // RL18
      ext = s.st == ST_EXT;
      // Byte seen at the target, before protection
      rd = 8'h00;
      if (prog)
         rd = mem_rdata_in; // RL4
      else if (is_id)
         rd = s.id[s.addr[2:0]]; // RL16
      else if (s.addr == DEVID_LO)
         rd = DEV_ID[7:0]; // RL14
      else if (s.addr == DEVID_HI)
         rd = DEV_ID[15:8]; // RL14
      else begin
         case (s.addr) // RL13
            CFG_DBG: begin
               rd[POS_DBG] = ~s.dbg_en;
               rd[POS_BSZ] = s.boot2k;
            end
            CFG_CP_USR: begin
               rd[POS_R0] = s.cp[RGN_B0];
               rd[POS_R1] = s.cp[RGN_B1];
            end
            CFG_CP_BOOT: rd[POS_BOOT] = s.cp[RGN_BOOT];
            CFG_WR_USR: begin
               rd[POS_R0] = s.wrt[RGN_B0];
               rd[POS_R1] = s.wrt[RGN_B1];
            end
            CFG_WR_BOOT: begin
               rd[POS_BOOT] = s.wrt[RGN_BOOT];
               rd[POS_CONFIG_WRITE_LOCK] = s.config_write_lock;
            end
            CFG_RD_USR: begin
               rd[POS_R0] = s.ebtr[RGN_B0];
               rd[POS_R1] = s.ebtr[RGN_B1];
            end
            CFG_RD_BOOT: rd[POS_BOOT] = s.ebtr[RGN_BOOT];
            default: rd = 8'h00;
         endcase
      end
      // Refusal: serial port sees only the external lock, core never does
      if (ext)
         deny = lk && !s.cp[rgn]; // RL6
      else if (s.wr)
         deny = (lk && !s.wrt[rgn]) || dbgr || (is_cfg && !s.config_write_lock); // RL7 RL13
      else
         deny = lk && !s.ebtr[rgn] && s.xrgn != rgn; // RL8 RL9 RL19
      // Serial receiver and reply shifter
      if (!s.pm_s2) begin
         n.cnt = 6'h00;
         n.txcnt = 4'h0;
         n.oe = 1'b0;
      end else if (rise && s.txcnt != 4'h0) begin
         n.tx = {1'b0, s.tx[7:1]}; // RL17
         n.txcnt = s.txcnt - 4'h1;
         n.oe = s.txcnt != 4'h1;
      end else if (rise && !s.ext_pend) begin
         n.sh = {s.pgd_s2, s.sh[35:1]}; // RL17
         n.cnt = s.cnt + 6'h01;
         if (s.cnt == FRAME_BITS - 6'h01) begin
            n.cnt = 6'h00;
            er_rgn = pmcp_rgn(n.sh[25:4], s.boot2k);
            case (n.sh[3:0])
               CMD_RD, CMD_WR: n.ext_pend = 1'b1;
               CMD_CHIP_ER: begin
                  n.cp = LOCK_RST; // RL11
                  n.wrt = LOCK_RST;
                  n.ebtr = LOCK_RST;
                  n.config_write_lock = 1'b1;
                  n.dbg_en = 1'b0;
                  n.id = {8{ID_RST}};
                  n.erase = 1'b1;
                  n.erase_all = 1'b1;
               end
               CMD_RGN_ER: begin
                  if (er_rgn != RGN_NONE) begin
                     n.cp[er_rgn] = 1'b1; // RL11
                     n.wrt[er_rgn] = 1'b1;
                     n.ebtr[er_rgn] = 1'b1;
                     n.erase = 1'b1;
                     n.erase_rgn = er_rgn;
                  end
               end
               default: n.ext_pend = 1'b0;
            endcase
         end
      end
      // Access engine; a waiting serial access goes first so it cannot starve
      case (s.st)
         ST_IDLE: begin
            if (s.ext_pend) begin
               n.st = ST_EXT;
               n.ext_pend = 1'b0;
               n.wr = s.sh[3:0] == CMD_WR;
               n.addr = s.sh[25:4];
               n.wdata = s.sh[35:28];
            end else if (tbl_req_in) begin
               n.st = ST_CORE;
               n.wr = tbl_wr_in;
               n.addr = tbl_addr_in;
               n.wdata = tbl_wdata_in;
               n.xrgn = pmcp_rgn(tbl_exec_addr_in, s.boot2k); // RL19
            end
         end
         ST_CORE, ST_EXT: begin
            n.st = ST_IDLE;
            if (s.wr && !deny) begin
               if (prog)
                  n.we = 1'b1; // RL4
               else if (is_id)
                  n.id[s.addr[2:0]] = s.wdata; // RL15
               else begin
                  // Lock bytes only AND in; a cleared bit stays cleared
                  case (s.addr)
                     CFG_DBG: begin
                        n.dbg_en = ~s.wdata[POS_DBG]; // RL18
                        n.boot2k = s.wdata[POS_BSZ];
                     end
                     CFG_CP_USR: begin
                        n.cp[RGN_B0] = s.cp[RGN_B0] & s.wdata[POS_R0]; // RL10
                        n.cp[RGN_B1] = s.cp[RGN_B1] & s.wdata[POS_R1];
                     end
                     CFG_CP_BOOT: n.cp[RGN_BOOT] = s.cp[RGN_BOOT] & s.wdata[POS_BOOT];
                     CFG_WR_USR: begin
                        n.wrt[RGN_B0] = s.wrt[RGN_B0] & s.wdata[POS_R0]; // RL10
                        n.wrt[RGN_B1] = s.wrt[RGN_B1] & s.wdata[POS_R1];
                     end
                     CFG_WR_BOOT: begin
                        n.wrt[RGN_BOOT] = s.wrt[RGN_BOOT] & s.wdata[POS_BOOT];
                        if (ext)
                           n.config_write_lock = s.config_write_lock & s.wdata[POS_CONFIG_WRITE_LOCK]; // RL12
                     end
                     CFG_RD_USR: begin
                        n.ebtr[RGN_B0] = s.ebtr[RGN_B0] & s.wdata[POS_R0]; // RL10
                        n.ebtr[RGN_B1] = s.ebtr[RGN_B1] & s.wdata[POS_R1];
                     end
                     CFG_RD_BOOT: n.ebtr[RGN_BOOT] = s.ebtr[RGN_BOOT] & s.wdata[POS_BOOT];
                     default: n.we = 1'b0;
                  endcase
               end
            end
            if (ext) begin
               if (!s.wr) begin
                  n.tx = deny ? 8'h00 : rd; // RL6
                  n.txcnt = TX_BITS;
                  n.oe = 1'b1;
               end
            end else begin
               n.ack = 1'b1;
               n.blocked = deny;
               n.rdata = (s.wr || deny) ? 8'h00 : rd; // RL5 RL9
            end
         end
         default: n.st = ST_IDLE;
      endcase
      n.ready = n.st == ST_IDLE && !n.ext_pend;
   end

   // State register
   always_ff @(posedge mclk_in) begin
      if (!nrst_in)
         s <= S_RST;
      else
         s <= n;
   end

   // Outputs straight from the state flops
   assign tbl_ready_out = s.ready;
   assign tbl_ack_out = s.ack;
   assign tbl_blocked_out = s.blocked;
   assign tbl_rdata_out = s.rdata;
   assign mem_addr_out = s.addr;
   assign mem_wdata_out = s.wdata;
   assign mem_we_out = s.we;
   assign mem_erase_out = s.erase;
   assign mem_erase_all_out = s.erase_all;
   assign mem_erase_rgn_out = s.erase_rgn;
   assign pgd_out = s.tx[0];
   assign pgd_oe_out = s.oe;
   assign dbg_en_out = s.dbg_en;
   assign dbg_pins_out = {2{s.dbg_en}}; // RL18

   // Checks
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   a_core_ack_lat: assert property (tbl_req_in && tbl_ready_out |-> ##2 tbl_ack_out) // RL4
      else $error("core access not answered in two cycles");
   a_write_lock: assert property (s.st == ST_CORE && s.wr && lk && !s.wrt[rgn]
      |=> !mem_we_out && tbl_blocked_out) // RL7
      else $error("write reached a write-locked region");
   a_xread_zero: assert property (s.st == ST_CORE && !s.wr && lk && !s.ebtr[rgn] && s.xrgn != rgn
      |=> tbl_rdata_out == 8'h00) // RL9
      else $error("cross-region read returned data");
   a_own_read: assert property (s.st == ST_CORE && !s.wr && lk && s.xrgn == rgn
      |=> tbl_rdata_out == $past(mem_rdata_in)) // RL8
      else $error("in-region read lost its data");
   a_core_cp_free: assert property (s.st == ST_CORE && !s.wr && prog && !deny
      |=> tbl_rdata_out == $past(mem_rdata_in) && !tbl_blocked_out) // RL5
      else $error("external lock touched a core read");
   a_lock_one_way: assert property (!mem_erase_out |-> (s.cp & ~$past(s.cp)) == 3'h0
      && (s.wrt & ~$past(s.wrt)) == 3'h0 && (s.ebtr & ~$past(s.ebtr)) == 3'h0) // RL10
      else $error("protection bit rose without erase");
   a_ext_cp: assert property (s.st == ST_EXT && !s.wr && lk && !s.cp[rgn]
      |=> pgd_oe_out && s.tx == 8'h00) // RL6
      else $error("locked region leaked to serial port");
   a_config_write_lock_ro: assert property (s.st == ST_CORE |=> mem_erase_out || s.config_write_lock == $past(s.config_write_lock)) // RL12
      else $error("core changed config write lock");
   a_id_write: assert property (s.st == ST_CORE && s.wr && is_id
      |=> s.id[$past(s.addr[2:0])] == $past(s.wdata)) // RL15
      else $error("ID byte not written");
   a_dbg_rsv: assert property (s.st == ST_CORE && s.wr && dbgr |=> !mem_we_out) // RL18
      else $error("write reached debugger memory");
endmodule : pmcp_top
`default_nettype wire

// ### verilog/pmcp_pkg.sv
// Constants for the program memory protection unit
package pmcp_pkg;
   // Region boundaries
   localparam logic [21:0] BOOT_END_1K = 22'h0007FF;
   localparam logic [21:0] BOOT_END_2K = 22'h000FFF;
   localparam logic [21:0] BLK0_LO     = 22'h001000;
   localparam logic [21:0] BLK0_HI     = 22'h001FFF;
   localparam logic [21:0] BLK1_LO     = 22'h002000;
   localparam logic [21:0] BLK1_HI     = 22'h003FFF;
   localparam logic [21:0] DBG_RSV_LO  = 22'h003E00;
   // Special spaces
   localparam logic [21:0] ID_LO       = 22'h200000;
   localparam logic [21:0] ID_HI       = 22'h200007;
   localparam logic [21:0] CFG_LO      = 22'h300000;
   localparam logic [21:0] CFG_HI      = 22'h30000D;
   localparam logic [21:0] CFG_DBG     = 22'h300006;
   localparam logic [21:0] CFG_CP_USR  = 22'h300008;
   localparam logic [21:0] CFG_CP_BOOT = 22'h300009;
   localparam logic [21:0] CFG_WR_USR  = 22'h30000A;
   localparam logic [21:0] CFG_WR_BOOT = 22'h30000B;
   localparam logic [21:0] CFG_RD_USR  = 22'h30000C;
   localparam logic [21:0] CFG_RD_BOOT = 22'h30000D;
   localparam logic [21:0] DEVID_LO    = 22'h3FFFFE;
   localparam logic [21:0] DEVID_HI    = 22'h3FFFFF;
   // Field positions within the lock bytes
   localparam int POS_R0   = 0;
   localparam int POS_R1   = 1;
   localparam int POS_BOOT = 6;
   localparam int POS_CONFIG_WRITE_LOCK = 5;
   localparam int POS_DBG  = 7;
   localparam int POS_BSZ  = 3;
   // Reset and debugger figures
   localparam logic [2:0] LOCK_RST     = 3'h7;
   localparam logic [7:0] ID_RST       = 8'hFF;
   localparam int         DBG_STACK    = 2;
   localparam int         DBG_RAM_BYTE = 10;
   // Serial frame: command 4, address 22, spare 2, data 8, low bit first
   localparam logic [5:0] FRAME_BITS   = 6'h24;
   localparam logic [3:0] TX_BITS      = 4'h8;
   localparam logic [3:0] CMD_RD       = 4'h0;
   localparam logic [3:0] CMD_WR       = 4'h1;
   localparam logic [3:0] CMD_CHIP_ER  = 4'h2;
   localparam logic [3:0] CMD_RGN_ER   = 4'h3;
   // Region codes, also bit index of the lock vectors
   localparam logic [1:0] RGN_BOOT = 2'h0;
   localparam logic [1:0] RGN_B0   = 2'h1;
   localparam logic [1:0] RGN_B1   = 2'h2;
   localparam logic [1:0] RGN_NONE = 2'h3;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CORE = 2'b01, ST_EXT = 2'b10} pmcp_state_t;
endpackage : pmcp_pkg

// ### tb/pmcp_flash_model.sv
// Behavioural program flash behind the protection unit
`timescale 1ns/10ps
`default_nettype none
module pmcp_flash_model (
   // Clock
   input  wire logic        mclk_in,
   // Flash port
   input  wire logic [21:0] mem_addr_in,
   input  wire logic [7:0]  mem_wdata_in,
   input  wire logic        mem_we_in,
   input  wire logic        mem_erase_in,
   input  wire logic        mem_erase_all_in,
   input  wire logic [1:0]  mem_erase_rgn_in,
   output logic      [7:0]  mem_rdata_out
);
   logic [7:0] mem [0:16383];
   logic [1:0] rg;
   // Known pattern so that reads can be predicted
   initial begin
      for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h5A;
   end
   // Space above block1 is unimplemented and reads zero
   assign mem_rdata_out = (mem_addr_in <= 22'h003FFF) ? mem[mem_addr_in[13:0]] : 8'h00;
   // Program and erase; region code 0 boot, 1 block0, 2 block1
   always @(posedge mclk_in) begin
      if (mem_we_in && mem_addr_in <= 22'h003FFF) mem[mem_addr_in[13:0]] <= mem_wdata_in;
      if (mem_erase_in) begin
         for (int i = 0; i < 16384; i++) begin
            rg = i[13] ? 2'h2 : (i[12] ? 2'h1 : 2'h0);
            if (mem_erase_all_in || rg == mem_erase_rgn_in) mem[i] <= 8'hFF;
         end
      end
   end
endmodule : pmcp_flash_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the program memory protection unit
`timescale 1ns/10ps
`default_nettype none
module tb;
   import pmcp_pkg::*;
   typedef struct packed {logic w; logic [21:0] a; logic [21:0] x; logic [7:0] d; logic [7:0] e; logic b;} pmcp_row_t;
   logic mclk_in, nrst_in, tbl_req_in, tbl_wr_in, prog_mode_in, pgc_in, pgd_drv;
   logic [21:0] tbl_addr_in, tbl_exec_addr_in, mem_addr_out;
   logic [7:0] tbl_wdata_in, tbl_rdata_out, mem_wdata_out, rd, r;
   logic tbl_ready_out, tbl_ack_out, tbl_blocked_out, mem_we_out, mem_erase_out, mem_erase_all_out;
   logic pgd_out, pgd_oe_out, dbg_en_out, blk, er_all;
   logic [1:0] er_rg;
   logic [1:0] mem_erase_rgn_out, dbg_pins_out;
   wire logic [7:0] mem_rdata_in;
   wire logic pgd_in;
   int num_errors, cmp_count, er_cnt, e0;
   pmcp_row_t rows [11] = '{
      {1'b0, 22'h000010, 22'h0, 8'h00, 8'h4A, 1'b0}, {1'b0, 22'h001234, 22'h0, 8'h00, 8'h6E, 1'b0},
      {1'b0, 22'h002345, 22'h0, 8'h00, 8'h1F, 1'b0}, {1'b0, 22'h004000, 22'h0, 8'h00, 8'h00, 1'b0},
      {1'b0, 22'h200000, 22'h0, 8'h00, 8'hFF, 1'b0}, {1'b0, 22'h3FFFFE, 22'h0, 8'h00, 8'hE1, 1'b0},
      {1'b0, 22'h3FFFFF, 22'h0, 8'h00, 8'hC3, 1'b0}, {1'b1, 22'h001100, 22'h0, 8'h3C, 8'h00, 1'b0},
      {1'b0, 22'h001100, 22'h0, 8'h00, 8'h3C, 1'b0}, {1'b1, 22'h200003, 22'h0, 8'hA5, 8'h00, 1'b0},
      {1'b0, 22'h200003, 22'h0, 8'h00, 8'hA5, 1'b0}};
   // Data line level: device drives while enabled, else the bench
   assign pgd_in = pgd_oe_out ? pgd_out : pgd_drv;
   pmcp_top #(.DEV_ID(16'hC3E1)) pmcp_top_i (.mclk_in(mclk_in), .nrst_in(nrst_in), .tbl_req_in(tbl_req_in),
      .tbl_wr_in(tbl_wr_in), .tbl_addr_in(tbl_addr_in), .tbl_exec_addr_in(tbl_exec_addr_in),
      .tbl_wdata_in(tbl_wdata_in), .tbl_ready_out(tbl_ready_out), .tbl_ack_out(tbl_ack_out),
      .tbl_blocked_out(tbl_blocked_out), .tbl_rdata_out(tbl_rdata_out), .mem_rdata_in(mem_rdata_in),
      .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
      .mem_erase_out(mem_erase_out), .mem_erase_all_out(mem_erase_all_out), .mem_erase_rgn_out(mem_erase_rgn_out),
      .prog_mode_in(prog_mode_in), .pgc_in(pgc_in), .pgd_in(pgd_in), .pgd_out(pgd_out), .pgd_oe_out(pgd_oe_out),
      .dbg_en_out(dbg_en_out), .dbg_pins_out(dbg_pins_out));
   pmcp_flash_model pmcp_flash_model_i (.mclk_in(mclk_in), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
      .mem_we_in(mem_we_out), .mem_erase_in(mem_erase_out), .mem_erase_all_in(mem_erase_all_out),
      .mem_erase_rgn_in(mem_erase_rgn_out), .mem_rdata_out(mem_rdata_in));
   // Clock
   initial begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end
   // Erase pulses seen on the flash port
   always @(posedge mclk_in) begin
      if (mem_erase_out === 1'b1) begin
         er_cnt++;
         er_all = mem_erase_all_out;
         er_rg = mem_erase_rgn_out;
      end
   end
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask : cyc
   // One core table access; waits for ready with a bound, request held one cycle, answer awaited with a bound
   task acc(input logic w, input logic [21:0] a, input logic [21:0] x, input logic [7:0] d);
      int n;
      n = 0;
      while (tbl_ready_out !== 1'b1 && n < 40) begin cyc(1); n++; end
      tbl_req_in = 1'b1; tbl_wr_in = w; tbl_addr_in = a; tbl_exec_addr_in = x; tbl_wdata_in = d;
      cyc(1);
      tbl_req_in = 1'b0;
      n = 0;
      while (tbl_ack_out !== 1'b1 && n < 6) begin cyc(1); n++; end
      chk("ack", {7'h00, tbl_ack_out}, 8'h01);
      rd = tbl_rdata_out;
      blk = tbl_blocked_out;
   endtask : acc
   task ck(input logic w, input logic [21:0] a, input logic [21:0] x, input logic [7:0] d, input logic [7:0] e,
           input logic b);
      acc(w, a, x, d);
      chk("rdata", rd, e);
      chk("blocked", {7'h00, blk}, {7'h00, b});
   endtask : ck
   // One serial frame, low bit first; a read returns its reply byte
   task ser(input logic [3:0] c, input logic [21:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [35:0] f;
      int n;
      f = {d, 2'h0, a, c};
      q = 8'h00;
      prog_mode_in = 1'b1;
      for (int i = 0; i < 36; i++) begin
         pgd_drv = f[i]; cyc(4); pgc_in = 1'b1; cyc(4); pgc_in = 1'b0;
      end
      if (c == CMD_RD) begin
         n = 0;
         while (pgd_oe_out !== 1'b1 && n < 20) begin cyc(1); n++; end
         for (int i = 0; i < 8; i++) begin
            q[i] = pgd_out; pgc_in = 1'b1; cyc(5); pgc_in = 1'b0; cyc(4);
         end
         chk("oe", {7'h00, pgd_oe_out}, 8'h00);
      end
      cyc(12);
   endtask : ser
   task stop_test;
      $display("comparisons %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   // Watchdog: the whole run needs about 2300 cycles
   initial begin
      repeat (20000) @(posedge mclk_in);
      num_errors++;
      stop_test;
   end
   // Main sequence
   initial begin
      nrst_in = 1'b0; tbl_req_in = 1'b0; tbl_wr_in = 1'b0; tbl_addr_in = '0; tbl_exec_addr_in = '0;
      tbl_wdata_in = '0; prog_mode_in = 1'b0; pgc_in = 1'b0; pgd_drv = 1'b0; er_cnt = 0;
      cyc(10);
      nrst_in = 1'b1;
      chk("ready", {7'h00, tbl_ready_out}, 8'h01);
      chk("dbg", {6'h00, dbg_en_out, pgd_oe_out}, 8'h00);
      foreach (rows[i]) ck(rows[i].w, rows[i].a, rows[i].x, rows[i].d, rows[i].e, rows[i].b);
      // 1K boot: boot write lock ends at 0007FFh
      ck(1'b1, 22'h30000B, 22'h0, 8'hBF, 8'h00, 1'b0);
      ck(1'b1, 22'h0007FF, 22'h0, 8'h11, 8'h00, 1'b1);
      ck(1'b1, 22'h000800, 22'h0, 8'h22, 8'h00, 1'b0);
      ck(1'b0, 22'h000800, 22'h0, 8'h00, 8'h22, 1'b0);
      // Block0 write lock, one-way bit
      ck(1'b1, 22'h30000A, 22'h0, 8'hFE, 8'h00, 1'b0);
      ck(1'b1, 22'h001000, 22'h002000, 8'h33, 8'h00, 1'b1);
      ck(1'b1, 22'h002000, 22'h0, 8'h44, 8'h00, 1'b0);
      ck(1'b1, 22'h30000A, 22'h0, 8'hFF, 8'h00, 1'b0);
      acc(1'b0, 22'h30000A, 22'h0, 8'h00);
      chk("wlock", {7'h00, rd[POS_R0]}, 8'h00);
      // Block1 cross read lock
      ck(1'b1, 22'h30000C, 22'h0, 8'hFD, 8'h00, 1'b0);
      ck(1'b0, 22'h002010, 22'h001000, 8'h00, 8'h00, 1'b1);
      ck(1'b0, 22'h002010, 22'h002100, 8'h00, 8'h4A, 1'b0);
      // Block0 external lock
      ck(1'b1, 22'h300008, 22'h0, 8'hFE, 8'h00, 1'b0);
      ck(1'b0, 22'h001010, 22'h0, 8'h00, 8'h4A, 1'b0);
      ser(CMD_RD, 22'h001010, 8'h00, r);
      chk("ser_locked", r, 8'h00);
      ser(CMD_WR, 22'h001010, 8'h77, r);
      ck(1'b0, 22'h001010, 22'h0, 8'h00, 8'h4A, 1'b0);
      ser(CMD_RD, 22'h002010, 8'h00, r);
      chk("ser_open", r, 8'h4A);
      // Chip erase restores the protection bits
      e0 = er_cnt;
      ser(CMD_CHIP_ER, 22'h0, 8'h00, r);
      chk("erases", 8'(er_cnt - e0), 8'h01);
      chk("erase_all", {7'h00, er_all}, 8'h01);
      acc(1'b0, 22'h30000A, 22'h0, 8'h00);
      chk("wlock_er", {7'h00, rd[POS_R0]}, 8'h01);
      ck(1'b0, 22'h002010, 22'h001000, 8'h00, 8'hFF, 1'b0);
      // Debugger on; reserved area refuses writes
      ck(1'b1, CFG_DBG, 22'h0, 8'h7F, 8'h00, 1'b0);
      chk("dbg_on", {5'h00, dbg_en_out, dbg_pins_out}, 8'h07);
      ck(1'b1, 22'h003E00, 22'h0, 8'h55, 8'h00, 1'b1);
      // Config write lock cleared through the serial port only
      ser(CMD_WR, 22'h30000B, 8'hDF, r);
      acc(1'b0, 22'h30000B, 22'h0, 8'h00);
      chk("config_write_lock", {7'h00, rd[POS_CONFIG_WRITE_LOCK]}, 8'h00);
      ck(1'b1, CFG_DBG, 22'h0, 8'hFF, 8'h00, 1'b1);
      chk("dbg_kept", {7'h00, dbg_en_out}, 8'h01);
      // Region erase restores only that region's bits
      ser(CMD_WR, 22'h30000C, 8'hFD, r);
      e0 = er_cnt;
      ser(CMD_RGN_ER, 22'h002000, 8'h00, r);
      chk("rgn_erases", 8'(er_cnt - e0), 8'h01);
      chk("rgn_code", {5'h00, er_all, er_rg}, {5'h00, 1'b0, RGN_B1});
      acc(1'b0, 22'h30000C, 22'h0, 8'h00);
      chk("rlock_er", {6'h00, rd[POS_R1], rd[POS_R0]}, 8'h03);
      stop_test;
   end
endmodule : tb
`default_nettype wire
